/* rtl/ivp_consts.svh */
`ifndef IVP_CONSTS_SVH
`define IVP_CONSTS_SVH
// Overview of operation
// - Accept and arbitrate 43 interrupt sources: one non-maskable plus all maskable.
// - Maskable set is seven external pins and thirty-five on-chip peripheral requests.
// - Each maskable request has a three-bit level among eight used in arbitration.
// - Each maskable request has its own mask; masked requests never reach the CPU.
// - A pending request of higher level may interrupt servicing of a lower one.
// - External inputs are noise filtered, edge detected, with selectable valid edge.
// - Among equal levels the lowest default-priority number wins; zero is highest.
// - Reset from pin, watchdog or low voltage: code 0000H, vector zero, PC undefined.
// - Single non-maskable source is watchdog overflow, code 0010H, no priority.
// - Software traps give codes 004nH or 005nH, separate handler per group.
// - Illegal opcode and debug trap share code 0060H and one handler.
// - Maskable vectors sit in 16-byte slots; pins take 0080H to 00E0H in order.
// - On acknowledge save restored PC into the maskable or non-maskable saved-PC register.
// - Aborted short load, divide, prepare or dispose restores its own address.
// - For illegal opcode the saved PC equals faulting address plus 4.
// - Timer Q1 in six-phase mode: overflow is valley, match0 is crest, from option logic.
// - Watchdog request is taken even with interrupts disabled and beats all others.
// - Masked or blocked maskable requests stay pending, then serviced by priority.
`define IVP_NUM_MASKABLE 42
`define IVP_NUM_PINS 7
`define IVP_NUM_LEVELS 8
`define IVP_FILTER_LEN 3
`define IVP_CODE_RESET 16'h0000
`define IVP_CODE_NMI 16'h0010
`define IVP_CODE_TRAP0 16'h0040
`define IVP_CODE_TRAP1 16'h0050
`define IVP_CODE_EXC 16'h0060
`define IVP_ILL_PC_OFFSET 32'h0000_0004
`define IVP_EDGE_RISE 2'h1
`define IVP_EDGE_FALL 2'h2
`endif

/* rtl/ivp_pkg.sv */
package ivp_pkg;
  typedef enum logic [2:0] {
    IVP_CLS_MASKABLE = 3'h1,
    IVP_CLS_NMI = 3'h2,
    IVP_CLS_DEBUG = 3'h4
  } ivp_class_t;
  typedef logic [15:0] ivp_code_t;
  // Exception code of each default-priority index; also its handler address
  function automatic ivp_code_t ivp_vec_code(input logic [5:0] idx);
    logic [15:0] c;
    c = 16'h0000;
    if (idx <= 6'h07) c = 16'h0080 + {6'h00, idx, 4'h0};
    else if (idx <= 6'h11) c = 16'h0120 + {6'h00, idx - 6'h08, 4'h0};
    else if (idx <= 6'h1D) c = 16'h0240 + {6'h00, idx - 6'h12, 4'h0};
    else if (idx <= 6'h26) c = 16'h0340 + {6'h00, idx - 6'h1E, 4'h0};
    else if (idx <= 6'h28) c = 16'h0400 + {6'h00, idx - 6'h27, 4'h0};
    else c = 16'h0430;
    return c;
  endfunction : ivp_vec_code
endpackage : ivp_pkg

/* rtl/ivp_pin_if.sv */
`timescale 1ns/1ps
interface ivp_pin_if #(parameter int N = 7);
  logic [N-1:0] raw;
  logic [2*N-1:0] edge_sel;
  logic [N-1:0] pulse;
  modport filt (input raw, input edge_sel, output pulse);
  modport core (output raw, output edge_sel, input pulse);
endinterface : ivp_pin_if

/* rtl/ivp_pin_filter.sv */
`timescale 1ns/1ps
`include "ivp_consts.svh"
module ivp_pin_filter #(
  parameter int N = `IVP_NUM_PINS,
  parameter int FLT = `IVP_FILTER_LEN
) (
  input wire logic i_clk, // Core clock
  input wire logic i_rst_n, // Async reset, active low
  ivp_pin_if.filt pins // Raw pins in, edge pulses out
);
  if (FLT < 2) begin : g_bad_len
    $error("Filter length below 2");
  end
  localparam int WW = $clog2(FLT + 4);
  logic [WW-1:0] warm_r;
  logic warm;
  // Edges stay off until the filter holds the settled pin level after reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      warm_r <= '0;
    end else if (!warm) begin
      warm_r <= warm_r + WW'(1);
    end
  end
  assign warm = (warm_r == WW'(FLT + 3));
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      logic s1_r, s2_r, lvl_r, rise, fall;
      logic [FLT-1:0] hist_r;
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end else begin
          s1_r <= pins.raw[g];
          s2_r <= s1_r;
        end
      end
      // Level changes only after FLT equal samples
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          hist_r <= '0;
          lvl_r <= 1'b0;
        end else begin
          hist_r <= {hist_r[FLT-2:0], s2_r};
          if (&hist_r) lvl_r <= 1'b1;
          else if (~|hist_r) lvl_r <= 1'b0;
        end
      end
      assign rise = warm & (&hist_r) & ~lvl_r;
      assign fall = warm & (~|hist_r) & lvl_r;
      assign pins.pulse[g] = (rise & pins.edge_sel[2*g]) | (fall & pins.edge_sel[2*g+1]);
    end
  endgenerate
endmodule : ivp_pin_filter

/* rtl/ivp_core.sv */
`timescale 1ns/1ps
`include "ivp_consts.svh"
module ivp_core #(
  parameter int NM = `IVP_NUM_MASKABLE,
  parameter int NP = `IVP_NUM_PINS
) (
  input wire logic I_CORE_CLK, // Core clock
  input wire logic I_RST_N, // Async reset, active low
  input wire logic [NP-1:0] I_EXT_PIN, // External request pins (async)
  input wire logic [2*NP-1:0] I_EDGE_SEL, // Per pin {fall,rise} enables
  input wire logic [NM-NP-1:0] I_PERIPH_REQ, // Peripheral request pulses
  input wire logic I_TQ1_SIX_PHASE, // Timer Q1 six-phase mode
  input wire logic I_TQ1_OPT_VALLEY, // Option logic valley pulse
  input wire logic I_TQ1_OPT_CREST, // Option logic crest pulse
  input wire logic [NM-1:0] I_MASK, // Per-source mask, 1 masks
  input wire logic [3*NM-1:0] I_LEVEL, // Per-source level, 0 highest
  input wire logic I_WDT_NMI, // Watchdog overflow pulse
  input wire logic I_RST_PIN_SRC, // Reset pin cause seen
  input wire logic I_WDT_RST_SRC, // Watchdog reset cause
  input wire logic I_LV_RST_SRC, // Low-voltage reset cause
  input wire logic I_ID_FLAG, // Interrupt-disable flag
  input wire logic I_NP_FLAG, // NMI in-service flag
  input wire logic I_CPU_ACK, // CPU takes presented request
  input wire logic I_RETI, // Return from maskable service
  input wire logic I_TRAP, // Software trap pulse
  input wire logic [4:0] I_TRAP_VEC, // Trap operand
  input wire logic I_ILL_OPCODE, // Illegal opcode pulse
  input wire logic I_DBTRAP, // Debug trap pulse
  input wire logic [31:0] I_PC, // Address of current instruction
  input wire logic [31:0] I_NEXT_PC, // Address of following instruction
  input wire logic I_ABORTABLE, // Current instruction restarts on abort
  output logic O_REQ, // Interrupt request to CPU
  output logic [15:0] O_CODE, // Exception code
  output logic [31:0] O_HANDLER, // Handler address
  output logic O_EXC, // Exception taken pulse
  output logic [15:0] O_EXC_CODE, // Exception code of trap
  output logic [31:0] O_EXC_HANDLER, // Handler address of trap
  output logic O_RESET_VEC, // Reset vector presented
  output logic [31:0] O_MASK_SAVED_PC, // Maskable saved PC
  output logic [31:0] O_NMI_SAVED_PC, // NMI saved PC
  output logic [31:0] O_DBG_SAVED_PC, // Debug saved PC
  output logic [NM-1:0] O_PENDING // Pending requests
);
  if (NM != 42 || NP != 7) begin : g_bad_size
    $error("Source table fixed at 42 maskable, 7 pins");
  end

  ivp_pin_if #(.N(NP)) pin_bus ();
  assign pin_bus.raw = I_EXT_PIN;
  assign pin_bus.edge_sel = I_EDGE_SEL;
  ivp_pin_filter #(.N(NP), .FLT(`IVP_FILTER_LEN)) u_filt (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .pins(pin_bus.filt)
  );

  // Requests in default-priority order; index 13/14 are timer Q1
  logic [NM-1:0] raw_req;
  logic [NM-NP-1:0] per_req;
  always_comb begin
    per_req = I_PERIPH_REQ;
    if (I_TQ1_SIX_PHASE) begin
      per_req[13-NP] = I_TQ1_OPT_VALLEY;
      per_req[14-NP] = I_TQ1_OPT_CREST;
    end
  end
  assign raw_req = {per_req, pin_bus.pulse};

  logic [NM-1:0] pend_r, grant_vec;
  logic nmi_pend_r;
  logic [5:0] win_idx;
  logic [2:0] win_lvl;
  logic win_any;

  // Fixed search: strict less-than keeps lowest index on ties
  always_comb begin
    win_idx = 6'h00;
    win_lvl = 3'h7;
    win_any = 1'b0;
    for (int k = 0; k < NM; k++) begin
      if (pend_r[k] && !I_MASK[k]) begin
        if (!win_any || I_LEVEL[3*k +: 3] < win_lvl) begin
          win_any = 1'b1;
          win_idx = 6'(k);
          win_lvl = I_LEVEL[3*k +: 3];
        end
      end
    end
  end

  // In-service level stack, one bit per level
  logic [`IVP_NUM_LEVELS-1:0] isr_r, isr_nxt;
  logic [2:0] isr_top;
  logic isr_any;
  always_comb begin
    isr_top = 3'h7;
    isr_any = 1'b0;
    for (int l = `IVP_NUM_LEVELS - 1; l >= 0; l--) begin
      if (isr_r[l]) begin
        isr_top = 3'(l);
        isr_any = 1'b1;
      end
    end
  end

  logic mask_ok, take_mask, take_nmi;
  assign mask_ok = win_any && !I_ID_FLAG && !I_NP_FLAG
                   && (!isr_any || win_lvl < isr_top);
  assign take_nmi = O_REQ && I_CPU_ACK && O_CODE == `IVP_CODE_NMI;
  assign take_mask = O_REQ && I_CPU_ACK && O_CODE != `IVP_CODE_NMI;

  always_comb begin
    grant_vec = '0;
    if (take_mask) grant_vec[win_idx] = 1'b1;
  end

  // Pending flags: a new event wins over the grant clear
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pend_r <= '0;
    end else begin
      pend_r <= (pend_r & ~grant_vec) | raw_req;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      nmi_pend_r <= 1'b0;
    end else begin
      nmi_pend_r <= (nmi_pend_r & ~take_nmi) | I_WDT_NMI;
    end
  end

  always_comb begin
    isr_nxt = isr_r;
    if (I_RETI && isr_any) isr_nxt[isr_top] = 1'b0;
    if (take_mask) isr_nxt[win_lvl] = 1'b1;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      isr_r <= '0;
    end else begin
      isr_r <= isr_nxt;
    end
  end

  // Request presentation: NMI ignores I_ID_FLAG but is held off while I_NP_FLAG is set
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_REQ <= 1'b0;
      O_CODE <= 16'h0000;
      O_HANDLER <= 32'h0000_0000;
    end else if (nmi_pend_r && !I_NP_FLAG && !(O_REQ && I_CPU_ACK)) begin
      O_REQ <= 1'b1;
      O_CODE <= `IVP_CODE_NMI;
      O_HANDLER <= {16'h0000, `IVP_CODE_NMI};
    end else if (mask_ok && !(O_REQ && I_CPU_ACK)) begin
      O_REQ <= 1'b1;
      O_CODE <= ivp_pkg::ivp_vec_code(win_idx);
      O_HANDLER <= {16'h0000, ivp_pkg::ivp_vec_code(win_idx)};
    end else begin
      O_REQ <= 1'b0;
    end
  end

  // Exceptions: traps and exception traps
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_EXC <= 1'b0;
      O_EXC_CODE <= 16'h0000;
      O_EXC_HANDLER <= 32'h0000_0000;
    end else begin
      O_EXC <= I_TRAP | I_ILL_OPCODE | I_DBTRAP;
      if (I_ILL_OPCODE || I_DBTRAP) begin
        O_EXC_CODE <= `IVP_CODE_EXC;
        O_EXC_HANDLER <= {16'h0000, `IVP_CODE_EXC};
      end else if (I_TRAP) begin
        O_EXC_CODE <= (I_TRAP_VEC[4] ? `IVP_CODE_TRAP1 : `IVP_CODE_TRAP0)
                      | {12'h000, I_TRAP_VEC[3:0]};
        O_EXC_HANDLER <= {16'h0000,
                          I_TRAP_VEC[4] ? `IVP_CODE_TRAP1 : `IVP_CODE_TRAP0};
      end
    end
  end

  // Reset vector: any reset cause points to address zero, PC undefined
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RESET_VEC <= 1'b0;
    end else begin
      O_RESET_VEC <= I_RST_PIN_SRC | I_WDT_RST_SRC | I_LV_RST_SRC;
    end
  end

  logic [31:0] restore_pc;
  assign restore_pc = I_ABORTABLE ? I_PC : I_NEXT_PC;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_MASK_SAVED_PC <= 32'h0000_0000;
      O_NMI_SAVED_PC <= 32'h0000_0000;
      O_DBG_SAVED_PC <= 32'h0000_0000;
    end else begin
      if (take_mask) O_MASK_SAVED_PC <= restore_pc;
      if (take_nmi) O_NMI_SAVED_PC <= restore_pc;
      if (I_ILL_OPCODE) O_DBG_SAVED_PC <= I_PC + `IVP_ILL_PC_OFFSET;
      else if (I_DBTRAP) O_DBG_SAVED_PC <= I_NEXT_PC;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PENDING <= '0;
    end else begin
      O_PENDING <= pend_r;
    end
  end
endmodule : ivp_core

/* verif/ivp_cpu_model.sv */
`timescale 1ns/1ps
module ivp_cpu_model (
  input wire logic i_clk, // Clock
  input wire logic i_rst_n, // Reset
  input wire logic i_req, // Request
  input wire logic [3:0] i_wait, // Delay
  output logic o_ack // Ack
);
  logic [3:0] cnt_r;
  // Ack lasts one cycle after the chosen wait
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 4'h0;
      o_ack <= 1'b0;
    end else begin
      o_ack <= i_req && !o_ack && cnt_r >= i_wait;
      cnt_r <= (i_req && !o_ack) ? cnt_r + 4'h1 : 4'h0;
    end
  end
endmodule : ivp_cpu_model

/* verif/ivp_core_props.sv */
`timescale 1ns/1ps
module ivp_core_props #(
  parameter int NM = 42,
  parameter int NP = 7
) (
  input wire logic I_CORE_CLK, // In
  input wire logic I_RST_N, // In
  input wire logic I_CPU_ACK, // In
  input wire logic I_WDT_NMI, // In
  input wire logic I_ID_FLAG, // In
  input wire logic I_TRAP, // In
  input wire logic [4:0] I_TRAP_VEC, // In
  input wire logic I_ILL_OPCODE, // In
  input wire logic I_DBTRAP, // In
  input wire logic I_RST_PIN_SRC, // In
  input wire logic I_WDT_RST_SRC, // In
  input wire logic I_LV_RST_SRC, // In
  input wire logic [31:0] I_PC, // In
  input wire logic [31:0] I_NEXT_PC, // In
  input wire logic I_ABORTABLE, // In
  input wire logic O_REQ, // Out
  input wire logic [15:0] O_CODE, // Out
  input wire logic [31:0] O_HANDLER, // Out
  input wire logic O_EXC, // Out
  input wire logic [15:0] O_EXC_CODE, // Out
  input wire logic [31:0] O_EXC_HANDLER, // Out
  input wire logic [31:0] O_MASK_SAVED_PC, // Out
  input wire logic [31:0] O_DBG_SAVED_PC, // Out
  input wire logic [31:0] O_NMI_SAVED_PC, // Out
  input wire logic O_RESET_VEC // Out
);
  logic [31:0] rpc_w;
  assign rpc_w = I_ABORTABLE ? I_PC : I_NEXT_PC;
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_N);
  sequence s_ack;
    O_REQ && I_CPU_ACK;
  endsequence
  sequence s_trap_out;
    O_EXC && O_EXC_CODE == {8'h00, 3'h2, $past(I_TRAP_VEC)};
  endsequence
  a_ack_drop: assert property (s_ack |=> !O_REQ)
    else $error("request still up after ack");
  a_mask_pc: assert property (
    s_ack ##0 O_CODE != 16'h0010 |=> O_MASK_SAVED_PC == $past(rpc_w))
    else $error("maskable saved pc wrong");
  a_nmi_first: assert property (
    $rose(I_WDT_NMI) |-> ##[1:4] O_REQ && O_CODE == 16'h0010)
    else $error("watchdog request not presented");
  a_vec_slot: assert property (O_REQ |-> O_HANDLER == {16'h0000, O_CODE})
    else $error("handler differs from code");
  a_trap_code: assert property (I_TRAP |=> s_trap_out)
    else $error("trap code wrong");
  a_exc_vec: assert property (
    O_EXC |-> O_EXC_HANDLER == {16'h0000, O_EXC_CODE[15:4], 4'h0})
    else $error("trap handler wrong");
  a_illop_pc: assert property (
    I_ILL_OPCODE |=> O_EXC && O_EXC_CODE == 16'h0060 && O_DBG_SAVED_PC == $past(I_PC) + 32'h4)
    else $error("illegal opcode result wrong");
  a_id_hold: assert property ($past(I_ID_FLAG) && O_REQ |-> O_CODE == 16'h0010)
    else $error("maskable presented while disabled");
  a_rst_vec: assert property (
    I_RST_PIN_SRC || I_WDT_RST_SRC || I_LV_RST_SRC |=> O_RESET_VEC)
    else $error("reset vector not raised");
  a_nmi_pc: assert property (
    s_ack ##0 O_CODE == 16'h0010 |=> O_NMI_SAVED_PC == $past(rpc_w))
    else $error("nmi saved pc wrong");
  a_dbg_pc: assert property (
    I_DBTRAP && !I_ILL_OPCODE |=> O_EXC && O_EXC_CODE == 16'h0060
      && O_DBG_SAVED_PC == $past(I_NEXT_PC))
    else $error("debug trap result wrong");
endmodule : ivp_core_props
bind ivp_core ivp_core_props #(.NM(NM), .NP(NP)) i_ivp_core_props (.*);

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic I_CORE_CLK, I_RST_N, I_TQ1_SIX_PHASE, I_TQ1_OPT_VALLEY, I_TQ1_OPT_CREST, I_WDT_NMI;
  logic I_RST_PIN_SRC, I_WDT_RST_SRC, I_LV_RST_SRC, I_ID_FLAG, I_NP_FLAG, I_CPU_ACK, I_RETI;
  logic I_TRAP, I_ILL_OPCODE, I_DBTRAP, I_ABORTABLE, O_REQ, O_EXC, O_RESET_VEC, nmi_p;
  logic [6:0] I_EXT_PIN;
  logic [13:0] I_EDGE_SEL;
  logic [34:0] I_PERIPH_REQ;
  logic [41:0] I_MASK, O_PENDING, pend;
  logic [125:0] I_LEVEL;
  logic [4:0] I_TRAP_VEC;
  logic [31:0] I_PC, I_NEXT_PC, O_HANDLER, O_EXC_HANDLER;
  logic [31:0] O_MASK_SAVED_PC, O_NMI_SAVED_PC, O_DBG_SAVED_PC;
  logic [15:0] O_CODE, O_EXC_CODE;
  logic [3:0] ack_wait;
  logic [31:0] r, spc, pc_s;
  int seed = 50, n_fail = 0, tests_run = 0, cyc = 0, w, g, spc_k = 0;
  int isv [$];
  int bs [6] = '{8, 18, 30, 39, 41, 42};
  logic [15:0] bc [6] = '{16'h0080, 16'h0120, 16'h0240, 16'h0340, 16'h0400, 16'h0430};
  ivp_core i_ivp_core (.*);
  ivp_cpu_model i_ivp_cpu_model (.i_clk(I_CORE_CLK), .i_rst_n(I_RST_N), .i_req(O_REQ),
    .i_wait(ack_wait), .o_ack(I_CPU_ACK));
  initial begin
    I_CORE_CLK = 1'b0;
    forever #5 I_CORE_CLK = ~I_CORE_CLK;
  end
  // Unused slots are skipped by the segment table
  function automatic logic [15:0] code_of(input int i);
    int s;
    s = 0;
    for (int k = 0; k < 6; k++) begin
      if (i >= s && i < bs[k])
        return bc[k] + 16'(16 * (i - s));
      s = bs[k];
    end
    return 16'hFFFF;
  endfunction : code_of
  function automatic int win();
    int v, top;
    v = -1;
    top = isv.size() ? isv[$] : 8;
    if (I_ID_FLAG || I_NP_FLAG)
      return -1;
    for (int i = 0; i < 42; i++)
      if (pend[i] && !I_MASK[i] && I_LEVEL[3*i+:3] < top && (v < 0 ||
          I_LEVEL[3*i+:3] < I_LEVEL[3*v+:3]))
        v = i;
    return v;
  endfunction : win
  task automatic step(input int n);
    repeat (n) begin
      @(posedge I_CORE_CLK);
      #1;
      I_PC = $random(seed);
      I_NEXT_PC = I_PC + 32'h4;
      I_ABORTABLE = I_PC[7];
    end
  endtask : step
  task automatic bad(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : bad
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    bad({48'h0, got}, {48'h0, exp});
  endtask : chk
  task automatic chk_p(input logic [41:0] got, input logic [41:0] exp);
    bad({22'h0, got}, {22'h0, exp});
  endtask : chk_p
  task automatic close_out();
    $display("counts: %0d compared, %0d mismatched", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // Acks are looked at mid-cycle, where request and ack are settled
  always @(negedge I_CORE_CLK) begin
    cyc++;
    if (spc_k == 1)
      bad(O_MASK_SAVED_PC, spc);
    else if (spc_k == 2)
      bad(O_NMI_SAVED_PC, spc);
    spc_k = 0;
    if (cyc > 9000) begin
      n_fail++;
      close_out();
    end else if (O_REQ === 1'b1 && I_CPU_ACK === 1'b1) begin
      w = win();
      chk(O_CODE, nmi_p ? 16'h0010 : code_of(w));
      spc = I_ABORTABLE ? I_PC : I_NEXT_PC;
      spc_k = nmi_p ? 2 : 1;
      if (nmi_p)
        nmi_p = 1'b0;
      else if (w >= 0) begin
        pend[w] = 1'b0;
        isv.push_back(I_LEVEL[3*w+:3]);
      end
    end
  end
  initial begin
    {I_RST_N, I_TQ1_SIX_PHASE, I_TQ1_OPT_VALLEY, I_TQ1_OPT_CREST, I_WDT_NMI, I_ID_FLAG} = '0;
    {I_RST_PIN_SRC, I_WDT_RST_SRC, I_LV_RST_SRC, I_NP_FLAG, I_RETI, I_TRAP} = '0;
    {I_ILL_OPCODE, I_DBTRAP, I_EXT_PIN, I_PERIPH_REQ, I_MASK, I_TRAP_VEC, I_PC, I_NEXT_PC} = '0;
    {I_ABORTABLE, pend, nmi_p, ack_wait} = '0;
    I_EDGE_SEL = 14'h1555;
    I_LEVEL = 126'({$random(seed), $random(seed), $random(seed), $random(seed)});
    repeat (6) @(posedge I_CORE_CLK);
    #1 I_RST_N = 1'b1;
    step(2);
    for (int k = 0; k < 60; k++) begin
      r = $random(seed);
      ack_wait = 4'(r) & 4'h3;
      I_TQ1_SIX_PHASE = k >= 30;
      g = r[10:8] % 7;
      case (r[5:4])
        2'h0: begin
          I_PERIPH_REQ = 35'($random(seed)) & 35'($random(seed));
          {I_TQ1_OPT_CREST, I_TQ1_OPT_VALLEY} = r[7:6];
          for (int j = 0; j < 35; j++)
            if (I_PERIPH_REQ[j] && !(I_TQ1_SIX_PHASE && j inside {6, 7}))
              pend[j+7] = 1'b1;
          if (I_TQ1_SIX_PHASE)
            pend[14:13] = pend[14:13] | r[7:6];
          step(1);
          {I_PERIPH_REQ, I_TQ1_OPT_CREST, I_TQ1_OPT_VALLEY} = '0;
        end
        2'h1: begin
          I_RETI = isv.size() > 0;
          if (I_RETI)
            isv.pop_back();
          I_WDT_NMI = r[6] & !I_NP_FLAG;
          nmi_p = I_WDT_NMI;
          step(1);
          {I_RETI, I_WDT_NMI} = '0;
        end
        2'h2: begin
          I_EXT_PIN[g] = !I_EXT_PIN[g];
          step(1);
          I_EXT_PIN[g] = !I_EXT_PIN[g];
          step(10);
          I_EXT_PIN[g] = !I_EXT_PIN[g];
          if (I_EDGE_SEL[2*g + !I_EXT_PIN[g]])
            pend[g] = 1'b1;
        end
        default: begin
          I_MASK[r[13:8] % 42] = !I_MASK[r[13:8] % 42];
          {I_ID_FLAG, I_NP_FLAG} = {r[14] & r[15], r[16] & r[17] & r[18]};
          I_EDGE_SEL = 14'($random(seed));
          I_LEVEL = 126'({$random(seed), $random(seed), $random(seed), $random(seed)});
        end
      endcase
      step(30);
      chk_p(O_PENDING, pend);
    end
    $display("test arbitration done");
    for (int v = 0; v < 34; v++) begin
      {I_TRAP, I_ILL_OPCODE, I_DBTRAP, I_TRAP_VEC} = {v < 32, v == 32, v == 33, 5'(v)};
      pc_s = I_PC;
      step(1);
      {I_TRAP, I_ILL_OPCODE, I_DBTRAP} = '0;
      chk(O_EXC ? O_EXC_CODE : 16'hFFFF, v < 32 ? 16'h0040 + 16'(v) : 16'h0060);
      bad(O_EXC_HANDLER, v < 16 ? 32'h40 : v < 32 ? 32'h50 : 32'h60);
      if (v >= 32)
        bad(O_DBG_SAVED_PC, 32'(pc_s + 32'h4));
      step(1);
    end
    $display("test exceptions done");
    for (int c = 0; c < 3; c++) begin
      {I_RST_PIN_SRC, I_WDT_RST_SRC, I_LV_RST_SRC} = 3'h4 >> c;
      step(1);
      chk(O_RESET_VEC, 1'b1);
      {I_RST_PIN_SRC, I_WDT_RST_SRC, I_LV_RST_SRC} = 3'h0;
      step(1);
      chk(O_RESET_VEC, 1'b0);
    end
    $display("test reset causes done");
    close_out();
  end
endmodule : testbench
